/* common/pcm_cfg.svh */
// Purpose: constants for the processor-control move unit
// Assumes: big-endian bit numbering of instruction fields (bit 0 = MSB)
// Notes:   instruction bit n maps to vector bit 31-n
`ifndef PCM_CFG_SVH
`define PCM_CFG_SVH

// Primary and extended opcodes
`define PCM_OPC_PRIMARY      6'h1f
`define PCM_XO_MTCRF         10'h090
`define PCM_XO_MCRXR         10'h200
`define PCM_XO_MFCR          10'h013
`define PCM_XO_MTMSR         10'h092
`define PCM_XO_MFMSR         10'h053
`define PCM_XO_MTSPR         10'h1d3
`define PCM_XO_MFSPR         10'h153

// Special register numbers (user level)
`define PCM_SPR_XER          10'h001
`define PCM_SPR_LR           10'h008
`define PCM_SPR_CTR          10'h009
// Special register numbers (supervisor level)
`define PCM_SPR_SRR0         10'h01a
`define PCM_SPR_SRR1         10'h01b
`define PCM_SPR_SPRG0        10'h110
`define PCM_SPR_SPRG1        10'h111
`define PCM_SPR_SPRG2        10'h112
`define PCM_SPR_SPRG3        10'h113

// Reset values
`define PCM_CR_RST           32'h0000_0000
`define PCM_MSR_RST          32'h0000_0000
`define PCM_XER_RST          32'h0000_0000
`define PCM_SPR_RST          32'h0000_0000
// User-mode flag bit position (vector numbering)
`define PCM_MSR_USER_BIT     14
`endif

/* common/pcm_pkg.sv */
// Purpose: types for the processor-control move unit
// Assumes: nothing beyond the header constants
// Notes:   carriers for instruction issue and result
package pcm_pkg;
    typedef enum logic [2:0] {
        PCM_OP_NONE,
        PCM_OP_MTCRF,
        PCM_OP_MCRXR,
        PCM_OP_MFCR,
        PCM_OP_MTMSR,
        PCM_OP_MFMSR,
        PCM_OP_MTSPR,
        PCM_OP_MFSPR
    } pcm_op_e;

    typedef enum logic [1:0] {
        PCM_EXC_NONE,
        PCM_EXC_PRIV,
        PCM_EXC_EMUL
    } pcm_exc_e;

    typedef struct packed {
        logic        valid;
        logic [31:0] instr;
        logic [31:0] src;
    } pcm_issue_s;

    typedef struct packed {
        logic        valid;
        logic        wr_gpr;
        logic [4:0]  gpr_idx;
        logic [31:0] data;
        pcm_exc_e    exc;
    } pcm_result_s;
endpackage

/* src/pcm_move_unit.sv */
// Purpose: execute condition, machine-state and special register moves
// Assumes: one instruction issued per cycle, source operand already read
// Notes:   result and exception appear one cycle after issue
// Function
// - A field move loads each 4-bit condition field whose mask bit is set from the source.
// - The exception copy puts integer exception bits 0-3 in one field and clears them.
// - A condition read returns the whole 32-bit condition register.
// - A machine-state write loads the whole machine-state register from the source.
// - A machine-state write is supervisor-only and takes effect before the next instruction.
// - A machine-state read returns the current machine-state register.
// - A machine-state read is allowed only in supervisor mode.
// - A special write decodes the register number and loads that register from the source.
// - A special read decodes the register number and returns that register.
// - The 10-bit register number is instruction bits 16-20 high, 11-15 low.
// - Register number bit 0 set marks a supervisor-only register.
// - A defined supervisor register used in user mode raises a privilege exception.
// - An undefined register number raises emulation, or privilege in user mode with bit 0 set.
`timescale 1ns/1ps
`default_nettype none
`include "pcm_cfg.svh"

module pcm_move_unit (
    input  wire logic              I_CLK,
    input  wire logic              I_SYS_RST,
    input  wire pcm_pkg::pcm_issue_s i_issue,
    output pcm_pkg::pcm_result_s   o_result,
    output logic                   o_stall,
    output logic [31:0]            o_cond_reg,
    output logic [31:0]            o_machine_state_reg,
    output logic [31:0]            o_integer_exception_reg,
    output logic                   o_user_mode_flag
);
    import pcm_pkg::*;

    // Instruction field extraction, big-endian numbering
    function automatic logic [9:0] spr_number(input logic [31:0] ins);
        // Halves swapped: bits 16-20 high, 11-15 low
        spr_number = {ins[15:11], ins[20:16]};
    endfunction

    function automatic logic [4:0] ins_field(input logic [31:0] ins, input int lsb);
        ins_field = ins[lsb +: 5];
    endfunction

    // Supervisor marker: number bit 0 in big-endian terms, the top of the
    // low half, so value bit 4; shared by the defined and undefined paths
    function automatic logic spr_needs_super(input logic [9:0] num);
        spr_needs_super = num[4];
    endfunction

    logic [31:0] cond_reg;
    logic [31:0] machine_state_reg;
    logic [31:0] integer_exception_reg;
    logic [31:0] link_reg;
    logic [31:0] count_reg;
    logic [31:0] srr0;
    logic [31:0] srr1;
    logic [31:0] sprg [4];
    pcm_result_s result;

    logic [31:0] next_cond_reg;
    logic [31:0] next_machine_state_reg;
    logic [31:0] next_integer_exception_reg;
    logic [31:0] next_link_reg;
    logic [31:0] next_count_reg;
    logic [31:0] next_srr0;
    logic [31:0] next_srr1;
    logic [31:0] next_sprg [4];
    pcm_result_s next_result;

    pcm_op_e     op;
    logic [9:0]  special_purpose_reg;
    logic [7:0]  fxm;
    logic [2:0]  crf;
    logic        user_mode;
    logic        spr_defined;
    logic [31:0] spr_rdata;

    assign user_mode = machine_state_reg[`PCM_MSR_USER_BIT];

    // Opcode decode
    always_comb begin
        op = PCM_OP_NONE;
        if (i_issue.valid && i_issue.instr[31:26] == `PCM_OPC_PRIMARY) begin
            case (i_issue.instr[10:1])
                `PCM_XO_MTCRF: op = PCM_OP_MTCRF;
                `PCM_XO_MCRXR: op = PCM_OP_MCRXR;
                `PCM_XO_MFCR:  op = PCM_OP_MFCR;
                `PCM_XO_MTMSR: op = PCM_OP_MTMSR;
                `PCM_XO_MFMSR: op = PCM_OP_MFMSR;
                `PCM_XO_MTSPR: op = PCM_OP_MTSPR;
                `PCM_XO_MFSPR: op = PCM_OP_MFSPR;
                default:       op = PCM_OP_NONE;
            endcase
        end
        special_purpose_reg = spr_number(i_issue.instr);
        fxm = i_issue.instr[19:12];
        crf = i_issue.instr[25:23];
    end

    // Special register read mux and defined-number check
    always_comb begin
        spr_defined = 1'b1;
        spr_rdata   = 32'h0000_0000;
        case (special_purpose_reg)
            `PCM_SPR_XER:   spr_rdata = integer_exception_reg;
            `PCM_SPR_LR:    spr_rdata = link_reg;
            `PCM_SPR_CTR:   spr_rdata = count_reg;
            `PCM_SPR_SRR0:  spr_rdata = srr0;
            `PCM_SPR_SRR1:  spr_rdata = srr1;
            `PCM_SPR_SPRG0: spr_rdata = sprg[0];
            `PCM_SPR_SPRG1: spr_rdata = sprg[1];
            `PCM_SPR_SPRG2: spr_rdata = sprg[2];
            `PCM_SPR_SPRG3: spr_rdata = sprg[3];
            default:        spr_defined = 1'b0;
        endcase
    end

    // Architected state and result; all updates are single-cycle so a
    // following read sees the write directly from the registers
    always_comb begin
        next_cond_reg              = cond_reg;
        next_machine_state_reg     = machine_state_reg;
        next_integer_exception_reg = integer_exception_reg;
        next_link_reg              = link_reg;
        next_count_reg             = count_reg;
        next_srr0                  = srr0;
        next_srr1                  = srr1;
        next_sprg                  = sprg;
        next_result                = '0;
        next_result.valid          = (op != PCM_OP_NONE);
        next_result.gpr_idx        = ins_field(i_issue.instr, 21);
        next_result.exc            = PCM_EXC_NONE;
        case (op)
            PCM_OP_MTCRF: begin
                for (int i = 0; i < 8; i++) begin
                    // Field i is bits 4i..4i+3 in big-endian numbering
                    if (fxm[7 - i]) begin
                        next_cond_reg[31 - 4*i -: 4] = i_issue.src[31 - 4*i -: 4];
                    end
                end
            end
            PCM_OP_MCRXR: begin
                next_cond_reg[31 - 4*crf -: 4] = integer_exception_reg[31:28];
                next_integer_exception_reg[31:28] = 4'h0;
            end
            PCM_OP_MFCR: begin
                next_result.wr_gpr = 1'b1;
                next_result.data   = cond_reg;
            end
            PCM_OP_MTMSR: begin
                if (user_mode) begin
                    next_result.exc = PCM_EXC_PRIV;
                end else begin
                    next_machine_state_reg = i_issue.src;
                end
            end
            PCM_OP_MFMSR: begin
                if (user_mode) begin
                    next_result.exc = PCM_EXC_PRIV;
                end else begin
                    next_result.wr_gpr = 1'b1;
                    next_result.data   = machine_state_reg;
                end
            end
            PCM_OP_MTSPR, PCM_OP_MFSPR: begin
                if (!spr_defined) begin
                    // Undefined number: privilege only when user hits a supervisor number
                    if (user_mode && spr_needs_super(special_purpose_reg)) begin
                        next_result.exc = PCM_EXC_PRIV;
                    end else begin
                        next_result.exc = PCM_EXC_EMUL;
                    end
                end else if (user_mode && spr_needs_super(special_purpose_reg)) begin
                    // Defined supervisor register touched from user mode
                    next_result.exc = PCM_EXC_PRIV;
                end else if (op == PCM_OP_MFSPR) begin
                    next_result.wr_gpr = 1'b1;
                    next_result.data   = spr_rdata;
                end else begin
                    case (special_purpose_reg)
                        `PCM_SPR_XER:   next_integer_exception_reg = i_issue.src;
                        `PCM_SPR_LR:    next_link_reg = i_issue.src;
                        `PCM_SPR_CTR:   next_count_reg = i_issue.src;
                        `PCM_SPR_SRR0:  next_srr0 = i_issue.src;
                        `PCM_SPR_SRR1:  next_srr1 = i_issue.src;
                        `PCM_SPR_SPRG0: next_sprg[0] = i_issue.src;
                        `PCM_SPR_SPRG1: next_sprg[1] = i_issue.src;
                        `PCM_SPR_SPRG2: next_sprg[2] = i_issue.src;
                        `PCM_SPR_SPRG3: next_sprg[3] = i_issue.src;
                        default:        next_link_reg = link_reg;
                    endcase
                end
            end
            default: next_result.valid = 1'b0;
        endcase
    end

    // Register stage
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            cond_reg              <= `PCM_CR_RST;
            machine_state_reg     <= `PCM_MSR_RST;
            integer_exception_reg <= `PCM_XER_RST;
            link_reg              <= `PCM_SPR_RST;
            count_reg             <= `PCM_SPR_RST;
            srr0                  <= `PCM_SPR_RST;
            srr1                  <= `PCM_SPR_RST;
            for (int i = 0; i < 4; i++) begin
                sprg[i] <= `PCM_SPR_RST;
            end
            result                <= '0;
        end else begin
            cond_reg              <= next_cond_reg;
            machine_state_reg     <= next_machine_state_reg;
            integer_exception_reg <= next_integer_exception_reg;
            link_reg              <= next_link_reg;
            count_reg             <= next_count_reg;
            srr0                  <= next_srr0;
            srr1                  <= next_srr1;
            sprg                  <= next_sprg;
            result                <= next_result;
        end
    end

    // Every move completes in the cycle after issue and the next
    // instruction already sees the new state, so no drain stall is needed
    assign o_stall                 = 1'b0;
    // Outputs straight from the registers
    assign o_result                = result;
    assign o_cond_reg              = cond_reg;
    assign o_machine_state_reg     = machine_state_reg;
    assign o_integer_exception_reg = integer_exception_reg;
    assign o_user_mode_flag        = user_mode;
endmodule
`default_nettype wire

/* tb/pcm_move_unit_properties.sv */
// Purpose: port-level properties of the move unit
// Assumes: one clock, synchronous active-high reset
// Notes:   results are checked one edge after the taking edge
`timescale 1ns/1ps
`default_nettype none
`include "pcm_cfg.svh"
module pcm_move_unit_properties (
    input wire logic                 I_CLK,
    input wire logic                 I_SYS_RST,
    input wire pcm_pkg::pcm_issue_s  i_issue,
    input wire pcm_pkg::pcm_result_s o_result,
    input wire logic                 o_stall,
    input wire logic [31:0]          o_cond_reg,
    input wire logic [31:0]          o_machine_state_reg,
    input wire logic [31:0]          o_integer_exception_reg,
    input wire logic                 o_user_mode_flag
);
    import pcm_pkg::*;
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SYS_RST);
    logic        go;
    logic [9:0]  xo;
    logic [9:0]  special_purpose_reg;
    logic        known;
    logic [31:0] msk;
    logic [31:0] fld;
    logic [31:0] xd;
    // Decode of the offered instruction
    assign go    = i_issue.valid && (i_issue.instr[31:26] == `PCM_OPC_PRIMARY);
    assign xo    = i_issue.instr[10:1];
    assign special_purpose_reg   = {i_issue.instr[15:11], i_issue.instr[20:16]};
    assign known = special_purpose_reg inside {10'h001, 10'h008, 10'h009, 10'h01a, 10'h01b, [10'h110:10'h113]};
    assign fld   = 32'hf000_0000 >> (4 * i_issue.instr[25:23]);
    assign xd    = {8{o_integer_exception_reg[31:28]}};
    // Field mask spread to nibbles
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            msk[31-4*i -: 4] = {4{i_issue.instr[19-i]}};
        end
    end
    sequence s_op(logic [9:0] code);
        go && xo == code;
    endsequence
    a_answer_next: assert property (go && xo inside {`PCM_XO_MTCRF, `PCM_XO_MCRXR,
        `PCM_XO_MFCR, `PCM_XO_MTMSR, `PCM_XO_MFMSR, `PCM_XO_MTSPR, `PCM_XO_MFSPR}
        |=> o_result.valid) else $error("no answer one cycle after a move");
    a_field_merge: assert property (s_op(`PCM_XO_MTCRF) |=> o_cond_reg ==
        (($past(o_cond_reg) & ~$past(msk)) | ($past(i_issue.src) & $past(msk))))
        else $error("masked field load wrong");
    a_xer_copy: assert property (s_op(`PCM_XO_MCRXR) |=>
        o_integer_exception_reg == {4'h0, $past(o_integer_exception_reg[27:0])} &&
        o_cond_reg == (($past(o_cond_reg) & ~$past(fld)) | ($past(xd) & $past(fld))))
        else $error("exception bits copy wrong");
    a_cond_read: assert property (s_op(`PCM_XO_MFCR) |=> o_result.wr_gpr &&
        o_result.data == $past(o_cond_reg) && o_result.gpr_idx == $past(i_issue.instr[25:21]))
        else $error("condition read wrong");
    a_msr_load: assert property (s_op(`PCM_XO_MTMSR) ##0 !o_user_mode_flag
        |=> o_machine_state_reg == $past(i_issue.src)) else $error("state load wrong");
    a_msr_guard: assert property (go && o_user_mode_flag &&
        xo inside {`PCM_XO_MTMSR, `PCM_XO_MFMSR} |=> o_result.exc == PCM_EXC_PRIV &&
        !o_result.wr_gpr && $stable(o_machine_state_reg)) else $error("user state access");
    a_spr_priv: assert property (go && xo inside {`PCM_XO_MTSPR, `PCM_XO_MFSPR} &&
        o_user_mode_flag && known && special_purpose_reg[4] |=> o_result.exc == PCM_EXC_PRIV &&
        !o_result.wr_gpr) else $error("user access to supervisor register");
    a_undef_emul: assert property (go && xo inside {`PCM_XO_MTSPR, `PCM_XO_MFSPR} &&
        !o_user_mode_flag && !known |=> o_result.exc == PCM_EXC_EMUL)
        else $error("undefined register not emulated");
    a_undef_priv: assert property (go && xo inside {`PCM_XO_MTSPR, `PCM_XO_MFSPR} &&
        o_user_mode_flag && !known && special_purpose_reg[4] |=> o_result.exc == PCM_EXC_PRIV &&
        !o_result.wr_gpr) else $error("user undefined supervisor number not refused");
    a_never_stall: assert property (!o_stall)
        else $error("stall raised");
endmodule
bind pcm_move_unit pcm_move_unit_properties u_props (
    .I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .i_issue(i_issue), .o_result(o_result),
    .o_stall(o_stall), .o_cond_reg(o_cond_reg), .o_machine_state_reg(o_machine_state_reg),
    .o_integer_exception_reg(o_integer_exception_reg), .o_user_mode_flag(o_user_mode_flag));
`default_nettype wire

/* tb/pcm_move_unit_bench.sv */
// Purpose: directed bench for the move unit
// Assumes: inputs driven on the falling clock edge
// Notes:   user mode is entered last, only reset leaves it
`timescale 1ns/1ps
`default_nettype none
`include "pcm_cfg.svh"
module pcm_move_unit_bench;
    import pcm_pkg::*;
    logic        I_CLK = 1'b0;
    logic        I_SYS_RST = 1'b1;
    pcm_issue_s  i_issue = '0;
    pcm_result_s o_result;
    pcm_result_s res;
    logic        o_stall;
    logic        o_user_mode_flag;
    logic [31:0] o_cond_reg;
    logic [31:0] o_machine_state_reg;
    logic [31:0] o_integer_exception_reg;
    int          err_total = 0;
    int          comparisons = 0;
    pcm_move_unit uut (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .i_issue(i_issue),
        .o_result(o_result), .o_stall(o_stall), .o_cond_reg(o_cond_reg),
        .o_machine_state_reg(o_machine_state_reg), .o_user_mode_flag(o_user_mode_flag),
        .o_integer_exception_reg(o_integer_exception_reg));
    // 50 MHz clock
    always #10 I_CLK = ~I_CLK;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_res(input logic wr, input pcm_exc_e e);
        comparisons++;
        if ({res.valid, res.wr_gpr, res.exc} !== {1'b1, wr, e}) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, {res.valid, res.wr_gpr, res.exc},
                {1'b1, wr, e});
        end
    endtask
    // Number halves swap places in the instruction
    function automatic logic [9:0] sf(input logic [9:0] n);
        return {n[4:0], n[9:5]};
    endfunction
    // One instruction per call; valid stays up so calls run back to back
    task automatic run(input logic [9:0] xo, input logic [4:0] r, input logic [9:0] f,
        input logic [31:0] src);
        i_issue = '{1'b1, {6'h1f, r, f, xo, 1'b0}, src};
        @(negedge I_CLK);
        res = o_result;
        chk({31'h0, o_stall}, 32'h0);
    endtask
    task automatic t_fields();
        run(`PCM_XO_MTCRF, 5'h0, {1'b0, 8'ha5, 1'b0}, 32'h1234_5678);
        chk(o_cond_reg, 32'h1030_0608);
        run(`PCM_XO_MTCRF, 5'h0, {1'b0, 8'h0f, 1'b0}, 32'hcafe_f00d);
        chk(o_cond_reg, 32'h1030_f00d);
        run(`PCM_XO_MFCR, 5'h7, 10'h0, 32'h0);
        chk_res(1'b1, PCM_EXC_NONE);
        chk(res.data, 32'h1030_f00d);
        chk({27'h0, res.gpr_idx}, 32'h7);
        run(`PCM_XO_MTCRF, 5'h0, 10'h0, 32'hffff_ffff);
        chk(o_cond_reg, 32'h1030_f00d);
    endtask
    task automatic t_xer();
        run(`PCM_XO_MTSPR, 5'h0, sf(`PCM_SPR_XER), 32'hb000_0123);
        chk(o_integer_exception_reg, 32'hb000_0123);
        run(`PCM_XO_MCRXR, {3'h5, 2'h0}, 10'h0, 32'h0);
        chk(o_cond_reg, 32'h1030_fb0d);
        chk(o_integer_exception_reg, 32'h0000_0123);
        run(`PCM_XO_MCRXR, 5'h0, 10'h0, 32'h0);
        chk(o_cond_reg, 32'h0030_fb0d);
    endtask
    task automatic t_spr();
        logic [9:0] n [8] = '{10'h008, 10'h009, 10'h01a, 10'h01b, 10'h110, 10'h111,
            10'h112, 10'h113};
        foreach (n[k]) run(`PCM_XO_MTSPR, 5'h1, sf(n[k]), {16'h5a5a, 6'h0, n[k]});
        foreach (n[k]) begin
            run(`PCM_XO_MFSPR, 5'h2, sf(n[k]), 32'h0);
            chk_res(1'b1, PCM_EXC_NONE);
            chk(res.data, {16'h5a5a, 6'h0, n[k]});
        end
        run(`PCM_XO_MTSPR, 5'h2, sf(10'h002), 32'h0);
        chk_res(1'b0, PCM_EXC_EMUL);
    endtask
    task automatic t_msr();
        run(`PCM_XO_MTMSR, 5'h0, 10'h0, 32'h0000_1234);
        chk(o_machine_state_reg, 32'h0000_1234);
        run(`PCM_XO_MFMSR, 5'h3, 10'h0, 32'h0);
        chk(res.data, 32'h0000_1234);
        run(`PCM_XO_MTMSR, 5'h0, 10'h0, 32'h0000_4321);
        chk({31'h0, o_user_mode_flag}, 32'h1);
        run(`PCM_XO_MFMSR, 5'h3, 10'h0, 32'h0);
        chk_res(1'b0, PCM_EXC_PRIV);
    endtask
    task automatic t_user();
        run(`PCM_XO_MTMSR, 5'h0, 10'h0, 32'h0);
        chk_res(1'b0, PCM_EXC_PRIV);
        chk(o_machine_state_reg, 32'h0000_4321);
        run(`PCM_XO_MTSPR, 5'h0, sf(`PCM_SPR_SRR0), 32'h0);
        chk_res(1'b0, PCM_EXC_PRIV);
        run(`PCM_XO_MFSPR, 5'h4, sf(`PCM_SPR_SRR0), 32'h0);
        chk_res(1'b0, PCM_EXC_PRIV);
        run(`PCM_XO_MFSPR, 5'h4, sf(`PCM_SPR_LR), 32'h0);
        chk(res.data, 32'h5a5a_0008);
        run(`PCM_XO_MFSPR, 5'h4, sf(10'h010), 32'h0);
        chk_res(1'b0, PCM_EXC_PRIV);
        run(`PCM_XO_MFSPR, 5'h4, sf(10'h002), 32'h0);
        chk_res(1'b0, PCM_EXC_EMUL);
        run(10'h3ff, 5'h4, 10'h0, 32'h0);
        chk({31'h0, res.valid}, 32'h0);
    endtask
    // Mid-run reset leaves user mode and clears state
    task automatic t_reset();
        I_SYS_RST = 1'b1;
        run(`PCM_XO_MTMSR, 5'h0, 10'h0, 32'h0);
        chk({31'h0, res.valid}, 32'h0);
        @(negedge I_CLK);
        I_SYS_RST = 1'b0;
        chk({o_cond_reg | o_machine_state_reg, 31'h0, o_user_mode_flag}, 64'h0);
        run(`PCM_XO_MFMSR, 5'h3, 10'h0, 32'h0);
        chk_res(1'b1, PCM_EXC_NONE);
        chk(res.data, 32'h0);
    endtask
    task automatic tally_and_finish();
        $display("mismatches=%0d comparisons=%0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Main sequence after eight reset cycles
    initial begin
        repeat (8) @(negedge I_CLK);
        I_SYS_RST = 1'b0;
        chk(o_cond_reg | o_machine_state_reg | o_integer_exception_reg, 32'h0);
        t_fields();
        t_xer();
        t_spr();
        t_msr();
        t_user();
        t_reset();
        i_issue.valid = 1'b0;
        tally_and_finish();
    end
    // Watchdog well past the roughly 40 cycles of traffic
    initial begin
        repeat (500) @(posedge I_CLK);
        err_total++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
